// ---- fou_pkg.sv ----
// Package with register map, field positions and types for the flash operation control block.
package fou_pkg;

    // Register byte offsets on the peripheral bus.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CTRL_CLR_OFS = 8'h04;
    localparam logic [7:0] CTRL_SET_OFS = 8'h08;
    localparam logic [7:0] CTRL_INV_OFS = 8'h0C;
    localparam logic [7:0] KEY_OFS = 8'h10;

    // Control register field positions.
    localparam int TRIG_BIT = 15;
    localparam int PEN_BIT = 14;
    localparam int FAIL_BIT = 13;
    localparam int UVERR_BIT = 12;
    localparam int UVACT_BIT = 11;
    localparam int PIDL_BIT = 10;
    localparam int OPSEL_LSB = 0;
    localparam int OPSEL_MSB = 3;

    // Unlock key words.
    localparam logic [31:0] KEY_FIRST = 32'hAA99_6655;
    localparam logic [31:0] KEY_SECOND = 32'h5566_99AA;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Operation select codes.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_WORD = 4'h1,
        OP_DWORD = 4'h2,
        OP_ROW = 4'h3,
        OP_PAGE_ERASE = 4'h4,
        OP_ARRAY_ERASE = 4'h5,
        OP_NOP6 = 4'h6
    } fou_op_t;

    // Peripheral bus request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } fou_bus_req_t;

    // Request to the array engine.
    typedef struct packed {
        logic start;
        logic [3:0] op;
        logic [31:0] target;
    } fou_array_req_t;

endpackage

// ---- fou_unlock.sv ----
// Unlock key tracker that opens the control register for one bus transaction.
`timescale 1ns/100ps

module fou_unlock (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // Bus activity.
    input wire logic bus_xact,
    input wire logic key_wr,
    input wire logic [31:0] key_data,
    // Result.
    output logic unlocked
);

    logic first_seen;
    logic next_first_seen;
    logic next_unlocked;

    // First key recorded for the next transaction.
    assign next_first_seen = key_wr && (key_data == fou_pkg::KEY_FIRST);
    assign next_unlocked = key_wr && first_seen && (key_data == fou_pkg::KEY_SECOND);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            first_seen <= 1'b0;
            unlocked <= 1'b0;
        end else if (bus_xact) begin
            first_seen <= next_first_seen;
            unlocked <= next_unlocked;
        end
    end

endmodule

// ---- fou_ctrl.sv ----
// Flash operation control register, unlock gating and operation launch.
`timescale 1ns/100ps

// Notes on behaviour
// - Setting bit 15 starts the operation; hardware clears it on completion.
// - Trigger writes accepted only with enable set and fresh unlock.
// - Enable bit 14 permits trigger writes and powers undervoltage detector.
// - Failure flag bit 13 is read-only, set when an operation fails.
// - Undervoltage error bit 12 set when detector sees low voltage.
// - Undervoltage active bit 11 follows current low-voltage condition.
// - Idle power-down bit 10 removes array power in Idle when set.
// - Trigger with no-operation code clears flags and idle power-down bit.
// - Operation select writable only while enable bit is zero.
// - Codes 1-3 program word, double word, row; 0 and 6 do nothing.
// - Code four erases the page at the target location.
// - Code five erases whole array only when no page is protected.
// - Program and erase act only on unprotected targets.
// - After unlock, only the next bus transaction may write control.
// - Unlock key register is write-only and reads zero.
// - Enable bit returns to zero on any reset.
// - Control bits 31-16 and 9-4 read as zero.
// - Clear, set and invert aliases at offsets 4, 8 and 12.
module fou_ctrl (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // Peripheral bus.
    input wire fou_pkg::fou_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    // Array engine.
    input wire logic [31:0] target_location_reg,
    input wire logic target_protected,
    input wire logic any_page_protected,
    input wire logic array_done,
    input wire logic array_fail,
    output fou_pkg::fou_array_req_t array_req,
    // Undervoltage detector and power.
    input wire logic low_voltage,
    input wire logic idle_mode,
    output logic undervoltage_detector_en,
    output logic array_power_off
);

    // Control register state.
    logic trigger;
    logic program_enable;
    logic op_fail_flag;
    logic undervolt_error;
    logic undervolt_active;
    logic idle_powerdown_enable;
    logic [3:0] operation_select;
    logic busy;

    // Low voltage synchroniser.
    logic lv_meta;
    logic lv_sync;

    // Bus decode.
    logic bus_xact;
    logic ctrl_hit;
    logic key_wr;
    logic unlocked;
    logic [31:0] ctrl_word;
    logic [31:0] next_ctrl;
    logic [31:0] next_rdata;
    logic ctrl_wr_ok;
    logic next_trig_req;
    logic launch;
    logic nop_trigger;
    logic op_valid;
    logic [3:0] next_opsel;

    function automatic logic [31:0] alias_apply(input logic [7:0] addr,
                                                input logic [31:0] cur,
                                                input logic [31:0] wd);
        case (addr)
            fou_pkg::CTRL_OFS: alias_apply = wd;
            fou_pkg::CTRL_CLR_OFS: alias_apply = cur & ~wd;
            fou_pkg::CTRL_SET_OFS: alias_apply = cur | wd;
            fou_pkg::CTRL_INV_OFS: alias_apply = cur ^ wd;
            default: alias_apply = cur;
        endcase
    endfunction

    assign bus_xact = bus_req.wr || bus_req.rd;
    assign ctrl_hit = bus_req.wr && ((bus_req.addr == fou_pkg::CTRL_OFS)
        || (bus_req.addr == fou_pkg::CTRL_CLR_OFS)
        || (bus_req.addr == fou_pkg::CTRL_SET_OFS)
        || (bus_req.addr == fou_pkg::CTRL_INV_OFS));
    assign key_wr = bus_req.wr && (bus_req.addr == fou_pkg::KEY_OFS);

    always_comb begin
        ctrl_word = fou_pkg::ZERO_WORD;
        ctrl_word[fou_pkg::TRIG_BIT] = trigger;
        ctrl_word[fou_pkg::PEN_BIT] = program_enable;
        ctrl_word[fou_pkg::FAIL_BIT] = op_fail_flag;
        ctrl_word[fou_pkg::UVERR_BIT] = undervolt_error;
        ctrl_word[fou_pkg::UVACT_BIT] = undervolt_active;
        ctrl_word[fou_pkg::PIDL_BIT] = idle_powerdown_enable;
        ctrl_word[fou_pkg::OPSEL_MSB:fou_pkg::OPSEL_LSB] = operation_select;
    end

    assign next_ctrl = alias_apply(bus_req.addr, ctrl_word, bus_req.wdata);

    assign ctrl_wr_ok = ctrl_hit && unlocked;

    assign next_trig_req = ctrl_wr_ok && program_enable && !trigger
        && next_ctrl[fou_pkg::TRIG_BIT];
    assign launch = next_trig_req;

    assign next_opsel = (ctrl_wr_ok && !program_enable)
        ? next_ctrl[fou_pkg::OPSEL_MSB:fou_pkg::OPSEL_LSB] : operation_select;

    assign nop_trigger = launch && (operation_select == fou_pkg::OP_NOP);

    // array erase needs no protected page.
    always_comb begin
        case (operation_select)
            fou_pkg::OP_WORD, fou_pkg::OP_DWORD, fou_pkg::OP_ROW,
            fou_pkg::OP_PAGE_ERASE: op_valid = !target_protected;
            fou_pkg::OP_ARRAY_ERASE: op_valid = !any_page_protected;
            default: op_valid = 1'b0;
        endcase
    end

    assign next_rdata = (bus_req.rd && bus_req.addr == fou_pkg::CTRL_OFS)
        ? ctrl_word : fou_pkg::ZERO_WORD;

    fou_unlock u_unlock (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .bus_xact(bus_xact),
        .key_wr(key_wr),
        .key_data(bus_req.wdata),
        .unlocked(unlocked)
    );

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lv_meta <= 1'b0;
            lv_sync <= 1'b0;
        end else begin
            lv_meta <= low_voltage;
            lv_sync <= lv_meta;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            program_enable <= 1'b0;
            operation_select <= 4'h0;
            idle_powerdown_enable <= 1'b0;
        end else begin
            operation_select <= next_opsel;
            if (ctrl_wr_ok && !trigger) begin
                program_enable <= next_ctrl[fou_pkg::PEN_BIT];
            end
            if (nop_trigger) begin
                idle_powerdown_enable <= 1'b0;
            end else if (ctrl_wr_ok) begin
                idle_powerdown_enable <= next_ctrl[fou_pkg::PIDL_BIT];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            trigger <= 1'b0;
            busy <= 1'b0;
        end else if (launch) begin
            trigger <= 1'b1;
            busy <= op_valid;
        end else if (trigger && (!busy || array_done)) begin
            trigger <= 1'b0;
            busy <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            op_fail_flag <= 1'b0;
            undervolt_error <= 1'b0;
            undervolt_active <= 1'b0;
        end else begin
            undervolt_active <= program_enable && lv_sync;
            if (busy && array_done && array_fail) begin
                op_fail_flag <= 1'b1;
            end else if (nop_trigger) begin
                op_fail_flag <= 1'b0;
            end
            if (program_enable && lv_sync) begin
                undervolt_error <= 1'b1;
            end else if (nop_trigger) begin
                undervolt_error <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= fou_pkg::ZERO_WORD;
            array_req <= '0;
            undervoltage_detector_en <= 1'b0;
            array_power_off <= 1'b0;
        end else begin
            bus_rdata <= next_rdata;
            array_req.start <= launch && op_valid;
            array_req.op <= operation_select;
            array_req.target <= target_location_reg;
            undervoltage_detector_en <= next_ctrl[fou_pkg::PEN_BIT] && ctrl_wr_ok && !trigger
                ? 1'b1 : (ctrl_wr_ok && !trigger ? 1'b0 : program_enable);
            array_power_off <= idle_powerdown_enable && idle_mode;
        end
    end

endmodule

// ---- fou_ctrl_monitor.sv ----
// Assertion checker for the flash operation control block.
`timescale 1ns/100ps
module fou_ctrl_monitor (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic arst_n,
    // Peripheral bus.
    input wire fou_pkg::fou_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    // Array engine.
    input wire logic target_protected,
    input wire logic any_page_protected,
    input wire fou_pkg::fou_array_req_t array_req,
    // Power.
    input wire logic idle_mode,
    input wire logic undervoltage_detector_en,
    input wire logic array_power_off
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    wire rd_ctrl = bus_req.rd && bus_req.addr == fou_pkg::CTRL_OFS;
    wire rd_other = bus_req.rd && bus_req.addr != fou_pkg::CTRL_OFS;
    chk_other_reads_zero: assert property (
        rd_other |=> bus_rdata == fou_pkg::ZERO_WORD) else $error("nonzero read outside control");
    chk_unimpl_zero: assert property (
        rd_ctrl |=> bus_rdata[31:16] == 16'h0000 && bus_rdata[9:4] == 6'h00)
        else $error("unimplemented control bits read nonzero");
    chk_enable_detector: assert property (
        rd_ctrl |=> bus_rdata[14] == $past(undervoltage_detector_en))
        else $error("detector enable differs from enable bit");
    chk_start_code: assert property (
        array_req.start |-> array_req.op inside {[4'h1:4'h5]}) else $error("start for empty code");
    chk_start_unprot: assert property (
        array_req.start |-> !$past(target_protected)) else $error("start on protected target");
    chk_erase_all: assert property (
        array_req.start && array_req.op == fou_pkg::OP_ARRAY_ERASE |-> !$past(any_page_protected))
        else $error("array erase with a protected page");
    chk_start_pulse: assert property (
        array_req.start |=> !array_req.start) else $error("start longer than one cycle");
    chk_power_idle: assert property (
        array_power_off |-> $past(idle_mode)) else $error("array power off outside idle");
    chk_reset_enable: assert property (
        $rose(arst_n) |-> !undervoltage_detector_en) else $error("enable set after reset");
    cover property (array_req.start);
    cover property (array_req.start && array_req.op == fou_pkg::OP_PAGE_ERASE);
    cover property (array_power_off);
    cover property (rd_ctrl ##1 bus_rdata[13]);
endmodule
bind fou_ctrl fou_ctrl_monitor i_mon (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .target_protected(target_protected),
    .any_page_protected(any_page_protected), .array_req(array_req), .idle_mode(idle_mode),
    .undervoltage_detector_en(undervoltage_detector_en), .array_power_off(array_power_off));

// ---- tb.sv ----
// Self-checking testbench for the flash operation control block.
`timescale 1ns/100ps
module tb;
    logic ref_clk;
    logic arst_n;
    fou_pkg::fou_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    logic [31:0] target_location_reg;
    logic target_protected;
    logic any_page_protected;
    logic array_done;
    logic array_fail;
    fou_pkg::fou_array_req_t array_req;
    logic low_voltage;
    logic idle_mode;
    logic undervoltage_detector_en;
    logic array_power_off;
    logic exp_fail;
    logic [31:0] rd;
    int miscompares;
    int n_tests;
    int starts;
    fou_ctrl i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .target_location_reg(target_location_reg), .target_protected(target_protected),
        .any_page_protected(any_page_protected), .array_done(array_done),
        .array_fail(array_fail), .array_req(array_req), .low_voltage(low_voltage),
        .idle_mode(idle_mode), .undervoltage_detector_en(undervoltage_detector_en),
        .array_power_off(array_power_off));
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (array_req.start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_req <= '{1'b1, 1'b0, a, d};
    endtask
    task automatic rdreg(input logic [7:0] a);
        @(posedge ref_clk);
        bus_req <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge ref_clk);
        bus_req <= '0;
        #1;
        rd = bus_rdata;
    endtask
    task automatic unlock();
        wr(fou_pkg::KEY_OFS, fou_pkg::KEY_FIRST);
        wr(fou_pkg::KEY_OFS, fou_pkg::KEY_SECOND);
    endtask
    task automatic t_locked();
        rdreg(fou_pkg::KEY_OFS);
        check(rd, 32'h0000_0000);
        wr(fou_pkg::CTRL_OFS, 32'h0000_4004);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        wr(fou_pkg::KEY_OFS, fou_pkg::KEY_FIRST);
        wr(fou_pkg::KEY_OFS, 32'h1234_5678);
        wr(fou_pkg::KEY_OFS, fou_pkg::KEY_SECOND);
        wr(fou_pkg::CTRL_OFS, 32'h0000_4004);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        unlock();
        wr(fou_pkg::CTRL_SET_OFS, 32'h0000_8000);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        unlock();
        rdreg(fou_pkg::KEY_OFS);
        wr(fou_pkg::CTRL_SET_OFS, 32'h0000_4000);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        unlock();
        wr(fou_pkg::CTRL_OFS, 32'hFFFF_4004);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_4004);
        check({31'h0, undervoltage_detector_en}, 32'h0000_0001);
        unlock();
        wr(fou_pkg::CTRL_OFS, 32'h0000_4001);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_4004);
        $display("test locking done");
    endtask
    task automatic run_op(input logic [3:0] op, input logic tp, input logic ap, input logic fl,
        input logic exp);
        int s0;
        @(posedge ref_clk);
        target_protected <= tp;
        any_page_protected <= ap;
        array_fail <= fl;
        unlock();
        wr(fou_pkg::CTRL_CLR_OFS, 32'h0000_4000);
        unlock();
        wr(fou_pkg::CTRL_OFS, 32'h0000_4000 | 32'(op) | (op == 4'h0 ? 32'h0000_0400 : 32'h0000_0000));
        unlock();
        wr(fou_pkg::CTRL_SET_OFS, 32'h0000_8000);
        s0 = starts;
        @(posedge ref_clk);
        bus_req <= '0;
        repeat (3) @(posedge ref_clk);
        check(32'(starts - s0), 32'(exp));
        if (exp) begin
            check({28'h0, array_req.op}, 32'(op));
            check(array_req.target, target_location_reg);
            rdreg(fou_pkg::CTRL_OFS);
            check(rd & 32'h0000_8000, 32'h0000_8000);
            @(posedge ref_clk);
            array_done <= 1'b1;
            @(posedge ref_clk);
            array_done <= 1'b0;
            exp_fail = exp_fail || fl;
        end
        if (op == 4'h0) begin
            exp_fail = 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd & 32'h0000_A00F, {16'h0, 2'b00, exp_fail, 9'h0, op});
        $display("test operation %0h done", op);
    endtask
    task automatic t_uv_idle();
        @(posedge ref_clk);
        low_voltage <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd & 32'h0000_1800, 32'h0000_1800);
        @(posedge ref_clk);
        low_voltage <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rdreg(fou_pkg::CTRL_OFS);
        check(rd & 32'h0000_1800, 32'h0000_1000);
        unlock();
        wr(fou_pkg::CTRL_INV_OFS, 32'h0000_0400);
        @(posedge ref_clk);
        bus_req <= '0;
        idle_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check({31'h0, array_power_off}, 32'h0000_0001);
        idle_mode <= 1'b0;
        run_op(4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        check(rd & 32'h0000_3C00, 32'h0000_0000);
        $display("test undervoltage and idle done");
    endtask
    task automatic stop_test();
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        stop_test();
    end
    initial begin
        {arst_n, target_protected, any_page_protected, array_done, array_fail} = '0;
        {low_voltage, idle_mode, exp_fail, miscompares, n_tests, starts} = '0;
        bus_req = '0;
        target_location_reg = 32'h0000_0400;
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        t_locked();
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdreg(fou_pkg::CTRL_OFS);
        check(rd, 32'h0000_0000);
        for (int k = 0; k < 16; k++) begin
            run_op(4'(k), 1'b0, 1'b0, k == 1, k >= 1 && k <= 5);
        end
        run_op(4'h4, 1'b1, 1'b0, 1'b0, 1'b0);
        run_op(4'h5, 1'b0, 1'b1, 1'b0, 1'b0);
        t_uv_idle();
        stop_test();
    end
endmodule
